// file: logic/cpcr_regs.sv
// Channel enable, power configuration and status register group.
//
// Behaviour
// - Input enable bits 7..4 enable channels one to four, one and two on.
// - Output enable bits 7..4 drive output slots one to four, all off.
// - Power bit 7 powers the bias generator up when set, resets clear.
// - Power bit 6 powers every enabled channel, clearing it stops all.
// - Power bit 5 powers the PLL up when set and resets clear.
// - Without bit 4, enables only take effect while nothing records.
// - Bits 3..2 choose the live switch set, codes 2 and 3 are not used.
// - Power bit 0 turns the voice detector on when set.
// - Status bits 7 and 6 show channels one and two powered, reset 0.
// - Mode field 7..5 reads 4 asleep, 6 all off, 7 any channel on.
// - The mode status register reads 0x80 after reset.
// - Reserved low bits read zero and ignore writes, except power bit 1, which is read-write.
// - The checksum register resets to zero and reads the checksum.
// - Writing the checksum loads it; other writes advance it.
`timescale 1ns/1ns
`default_nettype none
`include "cpcr_map.svh"

module cpcr_regs
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire cpcr_pkg::cpcr_byte_t reg_page,
    input wire cpcr_pkg::cpcr_byte_t reg_addr,
    input wire cpcr_pkg::cpcr_byte_t reg_wdata,
    output cpcr_pkg::cpcr_byte_t reg_rdata,
    output logic reg_rvalid,
    input wire logic sleep_mode,
    output logic bias_gen_power,
    output logic pll_power,
    output logic voice_detect_on,
    output logic [3:0] chan_power_req,
    output logic [3:0] chan_powered,
    output logic [3:0] out_slot_drive,
    output cpcr_pkg::cpcr_mode_e device_mode_field
);
    import cpcr_pkg::*;

    // Register fields are held in channel order: index 0 is channel one.
    logic [3:0] input_en_q;
    logic [3:0] out_slot_q;
    logic bias_q;
    logic chpwr_q;
    logic pll_q;
    logic live_q;
    logic [1:0] set_q;
    logic rsvd_q;
    logic vad_q;
    cpcr_byte_t cksum_q;
    cpcr_byte_t cksum_d;
    cpcr_mode_e mode_q;
    logic [3:0] eff_en_q;
    logic [3:0] ramp_done;
    logic recording;

    // Page and offset match for the main page.
    function automatic logic reg_hit(input cpcr_byte_t page,
                                     input cpcr_byte_t addr,
                                     input cpcr_byte_t off);
        reg_hit = (page == `CPCR_PAGE_MAIN) && (addr == off);
    endfunction

    // Register bits 7..4 carry channels one..four, so order is reversed.
    function automatic logic [3:0] rev4(input logic [3:0] v);
        rev4 = {v[0], v[1], v[2], v[3]};
    endfunction

    // Input channel enables; reserved low bits are not stored.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            input_en_q <= rev4(4'(`CPCR_RST_IN_EN >> 4));
        else if (ce && reg_wr && reg_hit(reg_page, reg_addr, `CPCR_OFF_IN_EN))
            input_en_q <= rev4(reg_wdata[7:4]);
    end

    // Output slot enables; a clear bit leaves the slot undriven.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            out_slot_q <= rev4(4'(`CPCR_RST_OUT_EN >> 4));
        else if (ce && reg_wr &&
                 reg_hit(reg_page, reg_addr, `CPCR_OFF_OUT_EN))
            out_slot_q <= rev4(reg_wdata[7:4]);
    end

    // Power configuration; every field is plain read-write.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bias_q <= 1'(`CPCR_RST_PWR >> `CPCR_BIT_BIAS);
            chpwr_q <= 1'(`CPCR_RST_PWR >> `CPCR_BIT_CHPWR);
            pll_q <= 1'(`CPCR_RST_PWR >> `CPCR_BIT_PLL);
            live_q <= 1'(`CPCR_RST_PWR >> `CPCR_BIT_LIVE);
            set_q <= 2'(`CPCR_RST_PWR >> `CPCR_LSB_SET);
            rsvd_q <= 1'(`CPCR_RST_PWR >> `CPCR_BIT_RSVD);
            vad_q <= 1'(`CPCR_RST_PWR >> `CPCR_BIT_VAD);
        end
        else if (ce && reg_wr && reg_hit(reg_page, reg_addr, `CPCR_OFF_PWR))
        begin
            bias_q <= reg_wdata[`CPCR_BIT_BIAS];
            chpwr_q <= reg_wdata[`CPCR_BIT_CHPWR];
            pll_q <= reg_wdata[`CPCR_BIT_PLL];
            live_q <= reg_wdata[`CPCR_BIT_LIVE];
            set_q <= reg_wdata[`CPCR_MSB_SET:`CPCR_LSB_SET];
            rsvd_q <= reg_wdata[`CPCR_BIT_RSVD];
            vad_q <= reg_wdata[`CPCR_BIT_VAD];
        end
    end

    // A channel counts as recording once its power-up has settled.
    assign recording = |chan_powered;

    // Each channel picks up its enable only when switching is allowed.
    // Without live switching a newly enabled channel waits until every
    // recording channel has stopped, so a running stream is never glitched.
    // Reserved set codes are treated like code 0, the narrower set.
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_chan
            logic in_set;
            logic may_switch;

            assign in_set = (i < 2) || (set_q == `CPCR_SET_ONE_FOUR);
            assign may_switch = !recording || (live_q && in_set);

            always_ff @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                    eff_en_q[i] <= 1'b0;
                else if (ce && may_switch)
                    eff_en_q[i] <= input_en_q[i];
            end

            // The global bit overrides every individual enable.
            assign chan_power_req[i] = chpwr_q && eff_en_q[i];

            cpcr_chan_ramp u_ramp
            (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .ce(ce),
                .power_req(chan_power_req[i]),
                .power_done(ramp_done[i])
            );

            // Masking with the live request drops status in the same cycle.
            assign chan_powered[i] = ramp_done[i] && chan_power_req[i] &&
                                     input_en_q[i];
        end
    endgenerate

    // Device mode, registered from the sleep input and channel power.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            mode_q <= CPCR_MODE_SLEEP;
        else if (ce)
        begin
            if (sleep_mode)
                mode_q <= CPCR_MODE_SLEEP;
            else if (recording)
                mode_q <= CPCR_MODE_ACTIVE;
            else
                mode_q <= CPCR_MODE_IDLE;
        end
    end

    // Running checksum: address plus data of each other write, modulo 256.
    always_comb
    begin
        cksum_d = cksum_q;
        if (reg_wr)
        begin
            if (reg_hit(reg_page, reg_addr, `CPCR_OFF_CKSUM))
                cksum_d = reg_wdata;
            else
                cksum_d = cksum_q + reg_addr + reg_wdata;
        end
    end

    // Writes on every page are seen here, not only the main page.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            cksum_q <= `CPCR_RST_CKSUM;
        else if (ce)
            cksum_q <= cksum_d;
    end

    // Read port: data is captured one cycle after the request.
    // Unmapped offsets and other pages answer zero.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else if (ce)
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                if (reg_hit(reg_page, reg_addr, `CPCR_OFF_IN_EN))
                    reg_rdata <= {rev4(input_en_q), 4'h0};
                else if (reg_hit(reg_page, reg_addr, `CPCR_OFF_OUT_EN))
                    reg_rdata <= {rev4(out_slot_q), 4'h0};
                else if (reg_hit(reg_page, reg_addr, `CPCR_OFF_PWR))
                    reg_rdata <= {bias_q, chpwr_q, pll_q, live_q,
                                  set_q, rsvd_q, vad_q};
                else if (reg_hit(reg_page, reg_addr, `CPCR_OFF_STS0))
                    reg_rdata <= {chan_powered[0], chan_powered[1],
                                  6'h00};
                else if (reg_hit(reg_page, reg_addr, `CPCR_OFF_STS1))
                    reg_rdata <= {mode_q, 5'h00};
                else if (reg_hit(reg_page, reg_addr, `CPCR_OFF_CKSUM))
                    reg_rdata <= cksum_q;
                else
                    reg_rdata <= 8'h00;
            end
        end
    end

    // Control outputs straight from the register flip-flops.
    assign bias_gen_power = bias_q;
    assign pll_power = pll_q;
    assign voice_detect_on = vad_q;
    assign out_slot_drive = out_slot_q;
    assign device_mode_field = mode_q;

endmodule // cpcr_regs

`default_nettype wire

// file: logic/cpcr_map.svh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef CPCR_MAP_SVH
`define CPCR_MAP_SVH

`define CPCR_PAGE_MAIN 8'h00
`define CPCR_OFF_IN_EN 8'h73
`define CPCR_OFF_OUT_EN 8'h74
`define CPCR_OFF_PWR 8'h75
`define CPCR_OFF_STS0 8'h76
`define CPCR_OFF_STS1 8'h77
`define CPCR_OFF_CKSUM 8'h7e

`define CPCR_RST_IN_EN 8'hc0
`define CPCR_RST_OUT_EN 8'h00
`define CPCR_RST_PWR 8'h00
`define CPCR_RST_STS0 8'h00
`define CPCR_RST_STS1 8'h80
`define CPCR_RST_CKSUM 8'h00

`define CPCR_BIT_BIAS 7
`define CPCR_BIT_CHPWR 6
`define CPCR_BIT_PLL 5
`define CPCR_BIT_LIVE 4
`define CPCR_MSB_SET 3
`define CPCR_LSB_SET 2
`define CPCR_BIT_RSVD 1
`define CPCR_BIT_VAD 0
`define CPCR_MSB_MODE 7
`define CPCR_LSB_MODE 5

`define CPCR_SET_ONE_FOUR 2'h1

`define CPCR_CLK_PERIOD_NS 10
`define CPCR_PU_TIME_NS 10000
`define CPCR_PU_CYCLES \
    ((`CPCR_PU_TIME_NS + `CPCR_CLK_PERIOD_NS - 1) / `CPCR_CLK_PERIOD_NS)

`endif

// file: logic/cpcr_pkg.sv
// Types shared by the channel power control register files.
package cpcr_pkg;

    typedef logic [7:0] cpcr_byte_t;

    typedef enum logic [2:0]
    {
        CPCR_MODE_SLEEP = 3'h4,
        CPCR_MODE_IDLE = 3'h6,
        CPCR_MODE_ACTIVE = 3'h7
    } cpcr_mode_e;

    typedef enum logic [1:0]
    {
        CPCR_CH_OFF = 2'h0,
        CPCR_CH_RAMP = 2'h1,
        CPCR_CH_ON = 2'h2
    } cpcr_ch_state_e;

endpackage

// file: logic/cpcr_chan_ramp.sv
// Power-up sequencer of one converter channel.
`timescale 1ns/1ns
`default_nettype none
`include "cpcr_map.svh"

module cpcr_chan_ramp
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic power_req,
    output logic power_done
);
    import cpcr_pkg::*;

    localparam int unsigned PU_CYC = `CPCR_PU_CYCLES;
    localparam logic [10:0] PU_LAST = 11'(PU_CYC - 1);

    cpcr_ch_state_e state_q;
    logic [10:0] cnt_q;

    // Power-down is immediate; power-up waits out the settling time.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= CPCR_CH_OFF;
            cnt_q <= 11'h000;
        end
        else if (ce)
        begin
            case (state_q)
                CPCR_CH_OFF:
                begin
                    cnt_q <= 11'h000;
                    if (power_req)
                        state_q <= CPCR_CH_RAMP;
                end
                CPCR_CH_RAMP:
                begin
                    if (!power_req)
                        state_q <= CPCR_CH_OFF;
                    else if (cnt_q == PU_LAST)
                        state_q <= CPCR_CH_ON;
                    else
                        cnt_q <= cnt_q + 11'h001;
                end
                CPCR_CH_ON:
                begin
                    if (!power_req)
                        state_q <= CPCR_CH_OFF;
                end
                default:
                    state_q <= CPCR_CH_OFF;
            endcase
        end
    end

    // Registered done flag; the caller masks it with the live request.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            power_done <= 1'b0;
        else if (ce)
            power_done <= (state_q == CPCR_CH_ON) && power_req;
    end

endmodule // cpcr_chan_ramp

`default_nettype wire

// file: sim/cpcr_regs_assertions.sv
// Concurrent checks on the ports of the channel power register group.
`timescale 1ns/1ns
`default_nettype none
`include "cpcr_map.svh"
module cpcr_regs_checker
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire cpcr_pkg::cpcr_byte_t reg_page,
    input wire cpcr_pkg::cpcr_byte_t reg_addr,
    input wire cpcr_pkg::cpcr_byte_t reg_wdata,
    input wire cpcr_pkg::cpcr_byte_t reg_rdata,
    input wire logic reg_rvalid,
    input wire logic sleep_mode,
    input wire logic bias_gen_power,
    input wire logic pll_power,
    input wire logic voice_detect_on,
    input wire logic [3:0] chan_power_req,
    input wire logic [3:0] chan_powered,
    input wire logic [3:0] out_slot_drive,
    input wire cpcr_pkg::cpcr_mode_e device_mode_field
);
    import cpcr_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    // A write taken on page zero at one offset.
    sequence s_wr(o);
        ce && reg_wr && reg_page == 8'h00 && reg_addr == o;
    endsequence
    // A read taken on any page.
    sequence s_rd;
        ce && reg_rd;
    endsequence
    // Cycles for which channel one has been requested, saturating.
    // A status bit that rises before the settling time is a broken ramp.
    logic [10:0] req_one_cnt_q;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            req_one_cnt_q <= 11'h000;
        else if (ce && !chan_power_req[0])
            req_one_cnt_q <= 11'h000;
        else if (ce && req_one_cnt_q != 11'h7ff)
            req_one_cnt_q <= req_one_cnt_q + 11'h001;
    end
    a_read_answers: assert property (s_rd |=> reg_rvalid)
        else $error("read not answered");
    a_no_stray_valid: assert property (ce && !reg_rd |=> !reg_rvalid)
        else $error("read answer without a read");
    a_bias_follows: assert property (s_wr(8'h75) |=>
        bias_gen_power == $past(reg_wdata[7])) else $error("bias wrong");
    a_pll_follows: assert property (s_wr(8'h75) |=>
        pll_power == $past(reg_wdata[5])) else $error("pll wrong");
    a_voice_follows: assert property (s_wr(8'h75) |=>
        voice_detect_on == $past(reg_wdata[0])) else $error("vad wrong");
    a_slot_follows: assert property (s_wr(8'h74) |=>
        out_slot_drive == {$past(reg_wdata[4]), $past(reg_wdata[5]),
        $past(reg_wdata[6]), $past(reg_wdata[7])}) else $error("slot wrong");
    a_global_off: assert property (s_wr(8'h75) ##0 !reg_wdata[6] |=>
        chan_power_req == 4'h0) else $error("channels left on");
    a_powered_needs: assert property (
        (chan_powered & ~chan_power_req) == 4'h0)
        else $error("powered without request");
    a_settle_time: assert property (chan_powered[0] |->
        req_one_cnt_q >= `CPCR_PU_CYCLES) else $error("powered too early");
    a_sleep_mode: assert property (ce && sleep_mode |=>
        device_mode_field == CPCR_MODE_SLEEP) else $error("mode not sleep");
    a_active_mode: assert property (
        ce && !sleep_mode && chan_powered != 4'h0 |=>
        device_mode_field == CPCR_MODE_ACTIVE) else $error("not active");
endmodule // cpcr_regs_checker
bind cpcr_regs cpcr_regs_checker cpcr_regs_checker_i
(
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sleep_mode(sleep_mode), .bias_gen_power(bias_gen_power),
    .pll_power(pll_power), .voice_detect_on(voice_detect_on),
    .chan_power_req(chan_power_req), .chan_powered(chan_powered),
    .out_slot_drive(out_slot_drive), .device_mode_field(device_mode_field)
);
`default_nettype wire

// file: sim/cpcr_host_model.sv
// Host model that issues byte-wide register accesses to the block.
`timescale 1ns/1ns
`default_nettype none
module cpcr_host_model
(
    input wire logic ref_clk,
    input wire cpcr_pkg::cpcr_byte_t reg_rdata,
    input wire logic reg_rvalid,
    output logic reg_wr,
    output logic reg_rd,
    output cpcr_pkg::cpcr_byte_t reg_page,
    output cpcr_pkg::cpcr_byte_t reg_addr,
    output cpcr_pkg::cpcr_byte_t reg_wdata
);
    import cpcr_pkg::*;
    // The bus starts idle so nothing is taken before reset is released.
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_page = 8'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released address and data are inverted, so late sampling shows up.
    task automatic wr(input cpcr_byte_t pg, input cpcr_byte_t a,
                      input cpcr_byte_t d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_page <= pg;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // The answer is looked for on falling edges, where it has settled.
    task automatic rd(input cpcr_byte_t pg, input cpcr_byte_t a,
                      output cpcr_byte_t d, output logic ok);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_page <= pg;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        ok = 1'b0;
        d = 'x;
        for (int n = 0; n < 4 && !ok; n++)
        begin
            @(negedge ref_clk);
            ok = (reg_rvalid === 1'b1);
            d = reg_rdata;
        end
    endtask
endmodule // cpcr_host_model
`default_nettype wire

// file: sim/test_channel_power_control_regs.sv
// Self-checking bench for the channel power control register group.
`timescale 1ns/1ns
`default_nettype none
module test_channel_power_control_regs;
    import cpcr_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic sleep_mode = 1'b1;
    logic reg_wr, reg_rd, reg_rvalid, bias_gen_power, pll_power;
    logic voice_detect_on;
    cpcr_byte_t reg_page, reg_addr, reg_wdata, reg_rdata;
    logic [3:0] chan_power_req, chan_powered, out_slot_drive;
    cpcr_mode_e device_mode_field;
    int err_total = 0;
    int num_checks = 0;
    cpcr_regs cpcr_regs_i (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_page(reg_page),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sleep_mode(sleep_mode),
        .bias_gen_power(bias_gen_power), .pll_power(pll_power),
        .voice_detect_on(voice_detect_on), .chan_power_req(chan_power_req),
        .chan_powered(chan_powered), .out_slot_drive(out_slot_drive),
        .device_mode_field(device_mode_field));
    cpcr_host_model cpcr_host_model_i (.ref_clk(ref_clk),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    // Free-running 100 MHz clock.
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input cpcr_byte_t exp,
                       input cpcr_byte_t got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdc(input cpcr_byte_t pg, input cpcr_byte_t a,
                       input cpcr_byte_t exp);
        cpcr_byte_t d;
        logic ok;
        cpcr_host_model_i.rd(pg, a, d, ok);
        if (!ok)
        begin
            err_total++;
            $display("mismatch read answer expected 1 seen 0");
            summarize();
        end
        else
            chk($sformatf("reg %h", a), exp, d);
    endtask
    // Output pins are judged on the falling edge after the write lands.
    task automatic outs(input cpcr_byte_t exp);
        @(negedge ref_clk);
        chk("outputs", exp, {bias_gen_power, pll_power, voice_detect_on,
            1'b0, chan_power_req});
    endtask
    // The ramp takes about a thousand cycles; the wait is capped above it.
    task automatic wait_pwr(input logic [3:0] exp);
        int n;
        for (n = 0; n < 1100 && chan_powered !== exp; n++)
            @(negedge ref_clk);
        chk("powered", {4'h0, exp}, {4'h0, chan_powered});
        if (n == 1100)
            summarize();
    endtask
    task automatic t_reset();
        rdc(8'h00, 8'h73, 8'hc0);
        rdc(8'h00, 8'h74, 8'h00);
        rdc(8'h00, 8'h75, 8'h00);
        rdc(8'h00, 8'h76, 8'h00);
        rdc(8'h00, 8'h77, 8'h80);
        chk("mode pins", 8'h04, {5'h00, device_mode_field});
        rdc(8'h00, 8'h7e, 8'h00);
        @(posedge ref_clk);
        sleep_mode <= 1'b0;
        rdc(8'h00, 8'h77, 8'hc0);
        chk("mode pins", 8'h06, {5'h00, device_mode_field});
        $display("test reset done");
    endtask
    // Reserved low bits are only ever written with their reset value.
    task automatic t_reserved();
        cpcr_host_model_i.wr(8'h00, 8'h73, 8'hf0);
        rdc(8'h00, 8'h73, 8'hf0);
        cpcr_host_model_i.wr(8'h00, 8'h74, 8'h50);
        @(negedge ref_clk);
        chk("slots", 8'h0a, {4'h0, out_slot_drive});
        rdc(8'h00, 8'h74, 8'h50);
        cpcr_host_model_i.wr(8'h00, 8'h76, 8'hc0);
        rdc(8'h00, 8'h76, 8'h00);
        cpcr_host_model_i.wr(8'h00, 8'h77, 8'he0);
        rdc(8'h00, 8'h77, 8'hc0);
        cpcr_host_model_i.wr(8'h00, 8'h73, 8'hc0);
        $display("test reserved done");
    endtask
    // A write offered while the clock enable is low must not land.
    task automatic t_freeze();
        @(posedge ref_clk);
        ce <= 1'b0;
        cpcr_host_model_i.wr(8'h00, 8'h74, 8'hf0);
        @(posedge ref_clk);
        ce <= 1'b1;
        rdc(8'h00, 8'h74, 8'h50);
        $display("test freeze done");
    endtask
    task automatic t_power();
        cpcr_host_model_i.wr(8'h00, 8'h75, 8'he1);
        outs(8'he3);
        wait_pwr(4'h3);
        rdc(8'h00, 8'h76, 8'hc0);
        rdc(8'h00, 8'h77, 8'he0);
        cpcr_host_model_i.wr(8'h00, 8'h75, 8'h00);
        outs(8'h00);
        rdc(8'h00, 8'h77, 8'hc0);
        $display("test power done");
    endtask
    // Enables reach channels one and two one cycle after the register write once live switching is on, three and four only with set code 1.
    task automatic t_live();
        cpcr_host_model_i.wr(8'h00, 8'h75, 8'h40);
        wait_pwr(4'h3);
        cpcr_host_model_i.wr(8'h00, 8'h73, 8'h40);
        @(posedge ref_clk);
        outs(8'h03);
        rdc(8'h00, 8'h76, 8'h40);
        cpcr_host_model_i.wr(8'h00, 8'h75, 8'h50);
        cpcr_host_model_i.wr(8'h00, 8'h73, 8'h40);
        @(posedge ref_clk);
        outs(8'h02);
        cpcr_host_model_i.wr(8'h00, 8'h75, 8'h54);
        cpcr_host_model_i.wr(8'h00, 8'h73, 8'h70);
        @(posedge ref_clk);
        outs(8'h0e);
        cpcr_host_model_i.wr(8'h00, 8'h75, 8'h00);
        $display("test live done");
    endtask
    task automatic t_cksum();
        cpcr_host_model_i.wr(8'h00, 8'h7e, 8'h10);
        cpcr_host_model_i.wr(8'h01, 8'h05, 8'h20);
        cpcr_host_model_i.wr(8'h00, 8'h73, 8'hc0);
        rdc(8'h00, 8'h7e, 8'h68);
        rdc(8'h01, 8'h73, 8'h00);
        rdc(8'h00, 8'h72, 8'h00);
        $display("test checksum done");
    endtask
    // Reset is held for two cycles, then the scenarios run in turn.
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_reserved();
        t_freeze();
        t_power();
        t_live();
        t_cksum();
        summarize();
    end
endmodule // test_channel_power_control_regs
`default_nettype wire
